// ==== include/oms_pkg.sv ====
package oms_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int TRIM_STEP_NS = 1000;
	localparam int TRIM_STEP_CYC = (TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIM_CNT_W = 8;
	localparam logic [1:0] PAUSE_OLD = 2'h2;
	localparam logic [1:0] PAUSE_NEW = 2'h3;
	localparam int PIN_DIV = 4;

	// Register offsets (byte addresses)
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_TRIM = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_CTRL2 = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
	localparam logic [ADDR_W-1:0] OFS_FREQ = 12'h010;

	// Field positions
	localparam int CTRL_PS_LSB = 4;
	localparam int TRIM_LF_BIT = 7;
	localparam int TRIM_SW_BIT = 6;
	localparam int CTRL2_MED_BIT = 0;

	// Reset values
	localparam logic [2:0] PS_RESET = 3'h6;
	localparam logic [5:0] TRIM_RESET = 6'h00;

	// Postscaler codes and frequencies in kHz
	localparam logic [2:0] PS_16M = 3'h7;
	localparam logic [2:0] PS_8M = 3'h6;
	localparam logic [2:0] PS_4M = 3'h5;
	localparam logic [2:0] PS_500K = 3'h2;
	localparam logic [2:0] PS_31K = 3'h0;
	localparam logic [15:0] HF_TOP_KHZ = 16'h3e80;
	localparam logic [15:0] LF_KHZ = 16'h001f;
	localparam logic [17:0] MULT_LIMIT_KHZ = 18'h0fa00;

	typedef enum logic [2:0] {
		FOSC_EXT, FOSC_EXT_MULT, FOSC_XTAL, FOSC_XTAL_MULT,
		FOSC_INT_A, FOSC_INT_B, FOSC_INT_MULT_A, FOSC_INT_MULT_B
	} oms_fosc_t;

	typedef enum logic [1:0] {SRC_EXT, SRC_HF, SRC_MF, SRC_LF} oms_src_t;

	typedef enum logic [1:0] {SW_RUN, SW_OLD, SW_NEW} oms_sw_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} oms_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} oms_apb_rsp_t;

	typedef struct packed {
		logic pwrt;
		logic fscm;
		logic wdt;
		logic two_speed;
	} oms_feat_t;

	typedef struct packed {
		logic feedback_amp_en;
		logic ost_start;
		logic lp_osc_en;
		logic mult_en;
		logic mult_active;
		logic sysclk_run;
		oms_src_t src;
		logic [5:0] trim_applied;
		logic [15:0] dev_freq_khz;
	} oms_clk_stat_t;

	typedef struct packed {
		logic [2:0] ps_sel;
		logic lf_sel;
		logic sw_en;
		logic [5:0] trim;
		logic med_sel;
		logic [31:0] prdata;
		logic [2:0] sync;
		oms_sw_state_t sw_state;
		oms_src_t cur_src;
		oms_src_t tgt_src;
		logic [1:0] pause_cnt;
		logic [TRIM_CNT_W-1:0] trim_cnt;
		logic rst_seen;
		logic pin_out;
		logic pin_oe;
		logic gpio7;
		logic gpio6;
		oms_clk_stat_t stat;
	} oms_state_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic out;
	} oms_div_state_t;

endpackage

// ==== src/oms_clk_div.sv ====
`timescale 1ns/1ps
module oms_clk_div #(
	parameter int DIV = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Source edge
	input wire logic tick,
	// Divided level
	output logic clk_out
);

	oms_pkg::oms_div_state_t st_reg;
	oms_pkg::oms_div_state_t st_next;

	// Half period of DIV source ticks per output level
	always_comb
	begin
		st_next = st_reg;
		if (tick)
		begin
			if (st_reg.cnt == 8'(DIV / 2 - 1))
			begin
				st_next.cnt = 8'h00;
				st_next.out = ~st_reg.out;
			end
			else
				st_next.cnt = st_reg.cnt + 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign clk_out = st_reg.out;

endmodule

// ==== src/oms_osc_ctrl.sv ====
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module oms_osc_ctrl (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire oms_pkg::oms_apb_req_t apb_req,
	output oms_pkg::oms_apb_rsp_t apb_rsp,
	// Configuration and system events
	input wire oms_pkg::oms_fosc_t fosc_mode,
	input wire logic mult_cfg_enable,
	input wire logic [15:0] ext_freq_khz,
	input wire oms_pkg::oms_feat_t feature_en,
	input wire logic wake_pulse,
	// Oscillator pins
	input wire logic osc_input_pin,
	output logic osc_output_pin_o,
	output logic osc_output_pin_oe,
	output logic port_a_bit_seven_gpio,
	output logic port_a_bit_six_gpio,
	// Clock tree status
	output oms_pkg::oms_clk_stat_t clk_stat
);

	oms_pkg::oms_state_t st_reg;
	oms_pkg::oms_state_t st_next;

	logic is_ext;
	logic is_xtal;
	logic is_int;
	logic pins_a;
	logic pins_b;
	logic cfg_mult;
	logic mult_en;
	logic ps_ok;
	logic mult_ok;
	logic mult_act;
	logic ext_edge;
	logic ext_div;
	logic int_div;
	logic apb_setup;
	logic apb_access;
	logic addr_hit;
	oms_pkg::oms_src_t int_src;
	oms_pkg::oms_src_t want_src;
	logic [15:0] ps_freq;
	logic [17:0] ext_x4;
	logic [15:0] dev_freq;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Mode decode
	assign is_ext = (fosc_mode == oms_pkg::FOSC_EXT) || (fosc_mode == oms_pkg::FOSC_EXT_MULT);
	assign is_xtal = (fosc_mode == oms_pkg::FOSC_XTAL) || (fosc_mode == oms_pkg::FOSC_XTAL_MULT);
	assign is_int = !is_ext && !is_xtal;
	assign pins_a = (fosc_mode == oms_pkg::FOSC_INT_A) || (fosc_mode == oms_pkg::FOSC_INT_MULT_A);
	assign pins_b = (fosc_mode == oms_pkg::FOSC_INT_B) || (fosc_mode == oms_pkg::FOSC_INT_MULT_B);

	// Multiplier enable and legality
	assign cfg_mult = mult_cfg_enable || (fosc_mode == oms_pkg::FOSC_EXT_MULT)
		|| (fosc_mode == oms_pkg::FOSC_XTAL_MULT);
	assign mult_en = is_int ? st_reg.sw_en : (st_reg.sw_en || cfg_mult);
	assign ps_ok = (st_reg.ps_sel == oms_pkg::PS_16M) || (st_reg.ps_sel == oms_pkg::PS_8M)
		|| (st_reg.ps_sel == oms_pkg::PS_4M);
	assign mult_ok = is_int ? ps_ok : 1'b1;
	assign mult_act = mult_en && mult_ok;

	// Low range source choice
	always_comb
	begin
		int_src = oms_pkg::SRC_HF;
		if (st_reg.ps_sel <= oms_pkg::PS_500K)
		begin
			if (st_reg.lf_sel && st_reg.med_sel)
				int_src = oms_pkg::SRC_MF;
			else if (st_reg.lf_sel)
				int_src = oms_pkg::SRC_HF;
			else if (st_reg.ps_sel == oms_pkg::PS_31K)
				int_src = oms_pkg::SRC_LF;
		end
	end

	assign want_src = is_int ? int_src : oms_pkg::SRC_EXT;

	// Postscaler output frequency, 31 kHz floor
	assign ps_freq = (st_reg.ps_sel == oms_pkg::PS_31K) ? oms_pkg::LF_KHZ
		: (oms_pkg::HF_TOP_KHZ >> (3'h7 - st_reg.ps_sel));
	assign ext_x4 = {ext_freq_khz, 2'b00};

	// Device clock frequency with multiplier
	always_comb
	begin
		if (is_int)
		begin
			if (mult_act)
				dev_freq = 16'({ps_freq, 2'b00});
			else
				dev_freq = ps_freq;
		end
		else if (mult_act)
		begin
			if (ext_x4 > oms_pkg::MULT_LIMIT_KHZ)
				dev_freq = oms_pkg::MULT_LIMIT_KHZ[15:0];
			else
				dev_freq = ext_x4[15:0];
		end
		else
			dev_freq = ext_freq_khz;
	end

	// Pin synchroniser, edge taken after second stage
	assign ext_edge = st_reg.sync[1] && !st_reg.sync[2];

	function automatic logic src_tick(input oms_pkg::oms_src_t src, input logic edge_in);
		// Internal sources are modelled as ticking every cycle
		src_tick = (src == oms_pkg::SRC_EXT) ? edge_in : 1'b1;
	endfunction

	oms_clk_div #(
		.DIV(oms_pkg::PIN_DIV)
	) u_ext_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick(ext_edge),
		.clk_out(ext_div)
	);

	oms_clk_div #(
		.DIV(oms_pkg::PIN_DIV)
	) u_int_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick(st_reg.stat.sysclk_run),
		.clk_out(int_div)
	);

	// APB decode
	assign apb_setup = apb_req.psel && !apb_req.penable;
	assign apb_access = apb_req.psel && apb_req.penable;
	assign addr_hit = (apb_req.paddr == oms_pkg::OFS_CTRL) || (apb_req.paddr == oms_pkg::OFS_TRIM)
		|| (apb_req.paddr == oms_pkg::OFS_CTRL2) || (apb_req.paddr == oms_pkg::OFS_STATUS)
		|| (apb_req.paddr == oms_pkg::OFS_FREQ);

	always_comb
	begin
		st_next = st_reg;
		st_next.sync = {st_reg.sync[1:0], osc_input_pin};
		st_next.rst_seen = 1'b1;

		// Read data captured in setup, held through access
		if (apb_setup)
		begin
			case (apb_req.paddr)
				oms_pkg::OFS_CTRL: st_next.prdata = {25'h0, st_reg.ps_sel, 4'h0};
				oms_pkg::OFS_TRIM: st_next.prdata = {24'h0, st_reg.lf_sel, st_reg.sw_en, st_reg.trim};
				oms_pkg::OFS_CTRL2: st_next.prdata = {31'h0, st_reg.med_sel};
				oms_pkg::OFS_STATUS: st_next.prdata = {26'h0, st_reg.stat.feedback_amp_en,
					st_reg.stat.lp_osc_en, st_reg.cur_src, st_reg.stat.sysclk_run, st_reg.stat.mult_active};
				oms_pkg::OFS_FREQ: st_next.prdata = {16'h0, st_reg.stat.dev_freq_khz};
				default: st_next.prdata = 32'h0;
			endcase
		end

		// Writes on the access edge, low byte lane only
		if (apb_access && apb_req.pwrite && apb_req.pstrb[0])
		begin
			case (apb_req.paddr)
				oms_pkg::OFS_CTRL: st_next.ps_sel = apb_req.pwdata[oms_pkg::CTRL_PS_LSB +: 3];
				oms_pkg::OFS_TRIM:
				begin
					st_next.lf_sel = apb_req.pwdata[oms_pkg::TRIM_LF_BIT];
					st_next.sw_en = apb_req.pwdata[oms_pkg::TRIM_SW_BIT];
					st_next.trim = apb_req.pwdata[5:0];
				end
				oms_pkg::OFS_CTRL2: st_next.med_sel = apb_req.pwdata[oms_pkg::CTRL2_MED_BIT];
				default: st_next.med_sel = st_reg.med_sel;
			endcase
		end

		// Trim drifts one step per interval toward the written value
		if (st_reg.stat.trim_applied != st_reg.trim)
		begin
			if (st_reg.trim_cnt == oms_pkg::TRIM_CNT_W'(oms_pkg::TRIM_STEP_CYC - 1))
			begin
				st_next.trim_cnt = '0;
				if (st_reg.stat.trim_applied < st_reg.trim)
					st_next.stat.trim_applied = st_reg.stat.trim_applied + 6'h01;
				else
					st_next.stat.trim_applied = st_reg.stat.trim_applied - 6'h01;
			end
			else
				st_next.trim_cnt = st_reg.trim_cnt + 1'b1;
		end
		else
			st_next.trim_cnt = '0;

		// Glitch-free switch pause
		case (st_reg.sw_state)
			oms_pkg::SW_RUN:
			begin
				if (!st_reg.rst_seen)
					st_next.cur_src = want_src;
				else if (want_src != st_reg.cur_src)
				begin
					st_next.tgt_src = want_src;
					st_next.pause_cnt = 2'h0;
					st_next.sw_state = oms_pkg::SW_OLD;
				end
			end
			oms_pkg::SW_OLD:
			begin
				if (src_tick(st_reg.cur_src, ext_edge))
				begin
					if (st_reg.pause_cnt == oms_pkg::PAUSE_OLD - 2'h1)
					begin
						st_next.pause_cnt = 2'h0;
						st_next.cur_src = st_reg.tgt_src;
						st_next.sw_state = oms_pkg::SW_NEW;
					end
					else
						st_next.pause_cnt = st_reg.pause_cnt + 2'h1;
				end
			end
			oms_pkg::SW_NEW:
			begin
				if (src_tick(st_reg.cur_src, ext_edge))
				begin
					if (st_reg.pause_cnt == oms_pkg::PAUSE_NEW - 2'h1)
						st_next.sw_state = oms_pkg::SW_RUN;
					else
						st_next.pause_cnt = st_reg.pause_cnt + 2'h1;
				end
			end
			default: st_next.sw_state = oms_pkg::SW_RUN;
		endcase

		// Pins
		// Pin-out level held low in modes that show no clock
		st_next.pin_out = is_ext ? ext_div : (pins_a && int_div);
		st_next.pin_oe = is_ext || pins_a;
		st_next.gpio7 = is_int;
		st_next.gpio6 = pins_b;

		// Clock tree status
		st_next.stat.feedback_amp_en = is_xtal;
		st_next.stat.ost_start = is_xtal && (wake_pulse || !st_reg.rst_seen);
		st_next.stat.lp_osc_en = (st_next.cur_src == oms_pkg::SRC_LF) || (|feature_en);
		st_next.stat.mult_en = mult_en;
		st_next.stat.mult_active = mult_act;
		st_next.stat.sysclk_run = (st_next.sw_state == oms_pkg::SW_RUN);
		st_next.stat.src = st_next.cur_src;
		st_next.stat.dev_freq_khz = dev_freq;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_reg <= '0;
			st_reg.ps_sel <= oms_pkg::PS_RESET;
			st_reg.trim <= oms_pkg::TRIM_RESET;
			st_reg.stat.trim_applied <= oms_pkg::TRIM_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign apb_rsp.prdata = st_reg.prdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = apb_access && !addr_hit;
	assign osc_output_pin_o = st_reg.pin_out;
	assign osc_output_pin_oe = st_reg.pin_oe;
	assign port_a_bit_seven_gpio = st_reg.gpio7;
	assign port_a_bit_six_gpio = st_reg.gpio6;
	assign clk_stat = st_reg.stat;

	// Checks
	property p_ext_no_delay;
		(is_ext && st_reg.rst_seen) |=> !clk_stat.ost_start && !clk_stat.feedback_amp_en;
	endproperty
	a_ext_no_delay: assert property (p_ext_no_delay) else $error("start-up delay in external clock mode");

	property p_ext_pin_out;
		is_ext |=> osc_output_pin_oe && !port_a_bit_seven_gpio;
	endproperty
	a_ext_pin_out: assert property (p_ext_pin_out) else $error("external mode pin output not driven");

	property p_xtal_no_out;
		is_xtal |=> !osc_output_pin_oe && !osc_output_pin_o && clk_stat.feedback_amp_en;
	endproperty
	a_xtal_no_out: assert property (p_xtal_no_out) else $error("crystal mode pin or amplifier wrong");

	property p_mult_limit;
		(!is_int && mult_act && ext_freq_khz <= 16'h3e80)
			|=> clk_stat.dev_freq_khz == {$past(ext_freq_khz[13:0]), 2'b00};
	endproperty
	a_mult_limit: assert property (p_mult_limit) else $error("multiplied frequency not four times source");

	property p_int_sw_only;
		(is_int && !st_reg.sw_en) |=> !clk_stat.mult_en;
	endproperty
	a_int_sw_only: assert property (p_int_sw_only) else $error("config bit enabled internal multiplier");

	property p_ps_gate;
		(is_int && st_reg.ps_sel < 3'h5) |=> !clk_stat.mult_active && clk_stat.dev_freq_khz <= 16'h0fa0;
	endproperty
	a_ps_gate: assert property (p_ps_gate) else $error("multiplier active on bad postscaler");

	property p_reset_ps;
		!st_reg.rst_seen |-> st_reg.ps_sel == 3'h6 && st_reg.sw_state == oms_pkg::SW_RUN;
	endproperty
	a_reset_ps: assert property (p_reset_ps) else $error("postscaler not 110 after reset");

	property p_lp_on;
		(|feature_en) |=> clk_stat.lp_osc_en;
	endproperty
	a_lp_on: assert property (p_lp_on) else $error("low-power oscillator off with feature enabled");

	property p_pins_b;
		pins_b |=> !osc_output_pin_oe && port_a_bit_six_gpio && port_a_bit_seven_gpio;
	endproperty
	a_pins_b: assert property (p_pins_b) else $error("mode B pins not released");

	property p_pause;
		(st_reg.sw_state == oms_pkg::SW_RUN && st_reg.rst_seen && want_src != st_reg.cur_src
			&& want_src != oms_pkg::SRC_EXT && st_reg.cur_src != oms_pkg::SRC_EXT)
			|=> !clk_stat.sysclk_run [*5] ##1 clk_stat.sysclk_run;
	endproperty
	a_pause: assert property (p_pause) else $error("switch pause length wrong");

	property p_drift;
		$changed(clk_stat.trim_applied) |=> $stable(clk_stat.trim_applied) [*8];
	endproperty
	a_drift: assert property (p_drift) else $error("trim stepped too fast");

	c_ext_mult: cover property (is_ext && clk_stat.mult_active);
	c_int_mult: cover property (is_int && clk_stat.mult_active && clk_stat.dev_freq_khz == 16'hfa00);
	c_switch_done: cover property (!clk_stat.sysclk_run ##1 clk_stat.sysclk_run);
	c_trim_step: cover property ($changed(clk_stat.trim_applied));

endmodule

// ==== dv/oms_ext_src_model.sv ====
`timescale 1ns/1ps
// External clock source on the oscillator input pin
module oms_ext_src_model #(
	parameter int HALF_NS = 200,
	parameter int PHASE_NS = 13
) (
	// Control
	input wire logic run,
	// Pin
	output logic osc_pin
);
	// Held low while stopped so no stray edge reaches the synchroniser
	initial osc_pin = 1'b0;
	always
	begin
		if (run)
		begin
			#(HALF_NS) osc_pin = 1'b1;
			#(HALF_NS) osc_pin = 1'b0;
		end
		else
		begin
			@(run);
			// Offset keeps pin edges off the bench clock edges
			#(PHASE_NS);
		end
	end
endmodule

// ==== dv/oscillator_mode_pll_internal_clock_source_select_tb.sv ====
`timescale 1ns/1ps
module oscillator_mode_pll_internal_clock_source_select_tb;
	logic pclk;
	logic presetn;
	oms_pkg::oms_apb_req_t req;
	oms_pkg::oms_apb_rsp_t rsp;
	oms_pkg::oms_fosc_t mode;
	logic cfg_mult;
	logic [15:0] ext_khz;
	oms_pkg::oms_feat_t feat;
	logic wake;
	logic ext_run;
	logic osc_in;
	logic pin_o;
	logic pin_oe;
	logic gpio7;
	logic gpio6;
	oms_pkg::oms_clk_stat_t stat;
	logic pin_q;
	logic [31:0] rd;
	logic err;
	int n_fail;
	int check_count;
	int cyc;
	int ost_cnt;
	int tog_cnt;

	oms_osc_ctrl dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .fosc_mode(mode),
		.mult_cfg_enable(cfg_mult), .ext_freq_khz(ext_khz), .feature_en(feat), .wake_pulse(wake),
		.osc_input_pin(osc_in), .osc_output_pin_o(pin_o), .osc_output_pin_oe(pin_oe),
		.port_a_bit_seven_gpio(gpio7), .port_a_bit_six_gpio(gpio6), .clk_stat(stat));

	oms_ext_src_model #(.HALF_NS(200)) src (.run(ext_run), .osc_pin(osc_in));

	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// Event counters and hang guard
	always @(posedge pclk)
	begin
		cyc++;
		pin_q <= pin_o;
		if (pin_o !== pin_q)
			tog_cnt++;
		if (stat.ost_start === 1'b1)
			ost_cnt++;
		if (cyc == 20000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
		repeat (12) @(posedge pclk);
	endtask

	task do_reset(input oms_pkg::oms_fosc_t m);
		@(posedge pclk);
		presetn <= 1'b0;
		mode <= m;
		repeat (6) @(posedge pclk);
		ost_cnt = 0;
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
	endtask

	task t_reset_vals;
		do_reset(oms_pkg::FOSC_INT_A);
		apb(1'b0, oms_pkg::OFS_CTRL, 32'h0, 4'hf);
		check(rd, 32'h60);
		apb(1'b0, oms_pkg::OFS_TRIM, 32'h0, 4'hf);
		check(rd, 32'h0);
		apb(1'b0, oms_pkg::OFS_FREQ, 32'h0, 4'hf);
		check(rd, 32'h1f40);
		apb(1'b0, 12'h020, 32'h0, 4'hf);
		check(rd, 32'h0);
		check({31'h0, err}, 32'h1);
	endtask

	task t_pins;
		tog_cnt = 0;
		repeat (40) @(posedge pclk);
		check(tog_cnt >= 19 && tog_cnt <= 21, 1'b1);
		check({pin_oe, gpio7, gpio6}, 3'h6);
		do_reset(oms_pkg::FOSC_INT_B);
		check({pin_oe, gpio7, gpio6}, 3'h3);
		do_reset(oms_pkg::FOSC_INT_MULT_A);
		check({pin_oe, gpio7, gpio6}, 3'h6);
		do_reset(oms_pkg::FOSC_INT_MULT_B);
		check({pin_oe, gpio7, gpio6}, 3'h3);
	endtask

	task t_mult_int;
		logic [31:0] f;
		cfg_mult <= 1'b1;
		do_reset(oms_pkg::FOSC_INT_MULT_A);
		check(stat.mult_active, 1'b0);
		wr(oms_pkg::OFS_TRIM, 32'h40);
		check(stat.mult_active, 1'b1);
		for (int c = 0; c < 8; c++)
		begin
			wr(oms_pkg::OFS_CTRL, 32'(c) << 4);
			case (c)
				0: f = 32'h001f;
				1: f = 32'h00fa;
				2: f = 32'h01f4;
				3: f = 32'h03e8;
				4: f = 32'h07d0;
				5: f = 32'h3e80;
				6: f = 32'h7d00;
				default: f = 32'hfa00;
			endcase
			apb(1'b0, oms_pkg::OFS_FREQ, 32'h0, 4'hf);
			check(rd, f);
			check(stat.mult_active, c >= 5);
		end
		cfg_mult <= 1'b0;
	endtask

	task t_low_src;
		do_reset(oms_pkg::FOSC_INT_A);
		wr(oms_pkg::OFS_TRIM, 32'h80);
		wr(oms_pkg::OFS_CTRL2, 32'h1);
		wr(oms_pkg::OFS_CTRL, 32'h0);
		check(stat.src, oms_pkg::SRC_MF);
		wr(oms_pkg::OFS_CTRL2, 32'h0);
		check(stat.src, oms_pkg::SRC_HF);
		wr(oms_pkg::OFS_TRIM, 32'h0);
		apb(1'b0, oms_pkg::OFS_STATUS, 32'h0, 4'hf);
		check(rd[4:2], 3'h7);
		wr(oms_pkg::OFS_CTRL, 32'h60);
		check(stat.lp_osc_en, 1'b0);
		feat <= '{pwrt: 1'b0, fscm: 1'b0, wdt: 1'b1, two_speed: 1'b0};
		repeat (4) @(posedge pclk);
		check(stat.lp_osc_en, 1'b1);
		feat <= '0;
	endtask

	task t_trim;
		do_reset(oms_pkg::FOSC_INT_A);
		apb(1'b1, oms_pkg::OFS_TRIM, 32'h3, 4'hf);
		repeat (5) @(posedge pclk);
		check(stat.trim_applied < 6'h2, 1'b1);
		repeat (80) @(posedge pclk);
		check(stat.trim_applied, 6'h3);
		wr(oms_pkg::OFS_TRIM, 32'h1);
		repeat (60) @(posedge pclk);
		check(stat.trim_applied, 6'h1);
		apb(1'b1, oms_pkg::OFS_TRIM, 32'h3f, 4'he);
		apb(1'b0, oms_pkg::OFS_TRIM, 32'h0, 4'hf);
		check(rd, 32'h1);
	endtask

	task t_switch;
		int lows;
		lows = 0;
		do_reset(oms_pkg::FOSC_INT_A);
		wr(oms_pkg::OFS_CTRL, 32'h30);
		apb(1'b1, oms_pkg::OFS_CTRL, 32'h0, 4'hf);
		repeat (12)
		begin
			@(posedge pclk);
			if (stat.sysclk_run !== 1'b1)
				lows++;
		end
		check(lows, 5);
	endtask

	task t_ext;
		ext_khz <= 16'h2710;
		do_reset(oms_pkg::FOSC_EXT);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		repeat (4) @(posedge pclk);
		check(ost_cnt, 0);
		check({stat.feedback_amp_en, pin_oe}, 2'h1);
		ext_run <= 1'b1;
		@(posedge osc_in);
		tog_cnt = 0;
		repeat (16) @(posedge osc_in);
		ext_run <= 1'b0;
		check(tog_cnt >= 7 && tog_cnt <= 9, 1'b1);
		cfg_mult <= 1'b1;
		do_reset(oms_pkg::FOSC_EXT);
		check({stat.mult_en, stat.dev_freq_khz}, {1'b1, 16'h9c40});
		cfg_mult <= 1'b0;
		ext_khz <= 16'h4e20;
		do_reset(oms_pkg::FOSC_XTAL_MULT);
		check(stat.dev_freq_khz, 16'hfa00);
		do_reset(oms_pkg::FOSC_EXT_MULT);
		check(ost_cnt, 0);
		do_reset(oms_pkg::FOSC_XTAL);
		check(ost_cnt, 1);
		wake <= 1'b1;
		@(posedge pclk);
		wake <= 1'b0;
		ext_run <= 1'b1;
		tog_cnt = 0;
		repeat (60) @(posedge pclk);
		ext_run <= 1'b0;
		check(ost_cnt, 2);
		check({stat.feedback_amp_en, pin_oe, tog_cnt == 0}, 3'h5);
	endtask

	initial
	begin
		presetn = 1'b0;
		req = '0;
		mode = oms_pkg::FOSC_INT_A;
		cfg_mult = 1'b0;
		ext_khz = 16'h2710;
		feat = '0;
		wake = 1'b0;
		ext_run = 1'b0;
		n_fail = 0;
		check_count = 0;
		cyc = 0;
		t_reset_vals();
		t_pins();
		t_mult_int();
		t_low_src();
		t_trim();
		t_switch();
		t_ext();
		tally_and_finish();
	end
endmodule
